// *** shared/mccs_pkg.sv ***
/*
  Constants, register map and carrier types of the modem call-control
  settings bank. Assumes a 125 MHz mclk and a command interpreter that
  addresses each setting by its register number.
*/
package mccs_pkg;
  // ********************
  // Timing
  // ********************
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1_000_000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int DECADE        = 10;
  localparam int RING_IDLE_S   = 8;
  localparam logic [7:0] RING_IDLE_T = 8'(RING_IDLE_S * DECADE);
  localparam int TK_MS = 0;
  localparam int TK_HS = 1;
  localparam int TK_TS = 2;
  localparam int TK_S  = 3;

  // ********************
  // Register map
  // ********************
  localparam int NREG = 19;
  localparam int SL_ANS   = 0;
  localparam int SL_RING  = 1;
  localparam int SL_ESC   = 2;
  localparam int SL_EOL   = 3;
  localparam int SL_LF    = 4;
  localparam int SL_BS    = 5;
  localparam int SL_DTD   = 6;
  localparam int SL_CWAIT = 7;
  localparam int SL_PAUSE = 8;
  localparam int SL_CVAL  = 9;
  localparam int SL_CLOSS = 10;
  localparam int SL_TONE  = 11;
  localparam int SL_BIAS  = 12;
  localparam int SL_TEST  = 13;
  localparam int SL_PORT  = 14;
  localparam int SL_DTR   = 15;
  localparam int SL_RTS   = 16;
  localparam int SL_SIDE  = 17;
  localparam int SL_LOGON = 18;
  localparam logic [5:0] REG_NUM [NREG] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
    6'h09, 6'h0a, 6'h0b, 6'h0d, 6'h12, 6'h17, 6'h19, 6'h1a, 6'h20,
    6'h22};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h01, 8'h00, 8'h2b, 8'h0d, 8'h0a, 8'h08, 8'h02, 8'h3c, 8'h02,
    8'h06, 8'h0e, 8'h5f, 8'h04, 8'h00, 8'h1d, 8'h05, 8'h01, 8'h00,
    8'h00};
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff,
    8'hff};
  localparam logic [NREG-1:0] REG_VOL = 19'h0003a;

  // ********************
  // Fields and values
  // ********************
  localparam int PORT_RDL    = 0;
  localparam int PORT_SPD_LO = 1;
  localparam int PORT_SPD_HI = 3;
  localparam int PORT_PAR_LO = 4;
  localparam int PORT_PAR_HI = 5;
  localparam logic [7:0] ASCII_MAX    = 8'h7f;
  localparam logic [7:0] BS_MIN_PRINT = 8'h21;
  localparam logic [7:0] SIDE_OFF     = 8'hff;
  localparam logic [7:0] TONE_MIN_MS  = 8'h32;
  localparam logic [7:0] BIAS_LIM     = 8'h08;
  localparam logic [3:0] BIAS_MID     = 4'h4;
  localparam logic [2:0] LVL_NODLY_A  = 3'h2;
  localparam logic [2:0] LVL_NODLY_B  = 3'h4;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       soft_rst;
    logic [5:0] idx;
    logic [7:0] wdata;
  } mccs_req_t;

  typedef struct packed {
    logic [1:0] parity;
    logic [2:0] speed;
    logic       hs;
    logic       remote_digital_loopback;
  } mccs_port_t;
endpackage : mccs_pkg

// *** design/mccs_settings.sv ***
/*
  Setting-register bank of a dial-up modem with the timers and decoders
  that the settings steer. Assumes the command interpreter runs on mclk;
  line and terminal pins are asynchronous and are synchronised here.
*/
// Overview of operation
// [R1] Zero disables answering; n answers after n rings
// [R2] Indicator lit while auto-answer setting nonzero
// [R3] Ring counter counts rings, answer on match
// [R4] Ring counter clears after 8 s quiet
// [R5] Escape above 127 disables escape and hang-up
// [R6] End-of-line char executes line, ends responses
// [R7] Verbose mode sends line feed after return
// [R8] Backspace recognised only below 33
// [R9] Dial-tone delay unless result level 2 or 4
// [R10] Wait modifier waits dial tone up to carrier-wait
// [R11] Carrier within carrier-wait, also bounds silence wait
// [R12] Each pause waits pause-delay seconds
// [R13] Carrier valid after continuous validation time
// [R14] Carrier absent loss time disconnects call
// [R15] Dial tone lasts tone-duration ms, 50 minimum
// [R16] Rate bias 0..8, 4 means no bias
// [R17] Test duration bounds tests, zero runs forever
// [R18] Port setting loopback accept and parity fields
// [R19] Port speed field unless high-speed override set
// [R20] Terminal-ready change acted on after detect time
// [R21] CTS follows RTS after delay in hundredths
// [R22] Side-channel wait after carrier, 255 disables
// [R23] Soft reset restores nonstorable registers
// [R24] Every setting is an eight-bit read-write location; port register 0x17 masks writes to bits 7:6, which read as zero
`timescale 1ns/100ps
module mccs_settings #(
  parameter int CYC_MS = mccs_pkg::CYC_PER_MS
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire mccs_pkg::mccs_req_t req,
  output logic [7:0]              rd_data,
  output logic                    rd_ack,
  input  wire logic               ring_pin,
  input  wire logic               dtr_pin,
  input  wire logic               rts_pin,
  input  wire logic               carrier_pin,
  input  wire logic               dial_tone_pin,
  input  wire logic               sync_cmd_mode,
  input  wire logic               online,
  input  wire logic               high_speed_port_setting,
  input  wire logic               verbose_responses,
  input  wire logic [2:0]         result_level,
  input  wire logic               char_valid,
  input  wire logic [7:0]         char_in,
  input  wire logic               dial_start,
  input  wire logic               wait_tone_mod,
  input  wire logic               quiet_start,
  input  wire logic               pause_req,
  input  wire logic               tone_req,
  input  wire logic               connect_start,
  input  wire logic               call_end,
  input  wire logic               test_active,
  output logic                    auto_answer_indicator,
  output logic                    answer_now,
  output logic                    esc_en,
  output logic                    hangup_en,
  output logic                    exec_line,
  output logic                    esc_hit,
  output logic                    bs_hit,
  output logic [7:0]              eol_char,
  output logic [7:0]              lf_char,
  output logic                    lf_en,
  output logic                    dial_go,
  output logic                    dial_fail,
  output logic                    quiet_ok,
  output logic                    pause_done,
  output logic                    tone_on,
  output logic                    carrier_ok,
  output logic                    no_carrier,
  output logic                    side_go,
  output logic                    dtr_ok,
  output logic                    cts,
  output logic                    test_stop,
  output logic [3:0]              bias_step,
  output mccs_pkg::mccs_port_t    port_cfg,
  output logic [7:0]              logon_sel
);
  import mccs_pkg::*;

  // ********************
  // Time base
  // ********************
  logic [16:0] ms_cnt;
  logic        tick [4];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= 17'h00000;
      tick[TK_MS] <= 1'b0;
    end else if (ce) begin
      tick[TK_MS] <= ms_cnt == 17'(CYC_MS - 1);
      ms_cnt <= (ms_cnt == 17'(CYC_MS - 1)) ? 17'h00000 : ms_cnt + 17'h1;
    end
  end

  for (genvar k = 1; k < 4; k++) begin : g_dec
    logic [3:0] cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        cnt <= 4'h0;
        tick[k] <= 1'b0;
      end else if (ce) begin
        tick[k] <= tick[k-1] && cnt == 4'(DECADE - 1);
        if (tick[k-1]) begin
          cnt <= (cnt == 4'(DECADE - 1)) ? 4'h0 : cnt + 4'h1;
        end
      end
    end
  end

  // ********************
  // Pin synchronisers
  // ********************
  // Bits: ring, dtr, rts, carrier, dial tone
  logic [4:0] pin_m;
  logic [4:0] pin_s;
  logic       ring_d;
  wire        ring_evt = pin_s[0] && !ring_d;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m  <= 5'h00;
      pin_s  <= 5'h00;
      ring_d <= 1'b0;
    end else if (ce) begin
      pin_m  <= {dial_tone_pin, carrier_pin, rts_pin, dtr_pin, ring_pin};
      pin_s  <= pin_m;
      ring_d <= pin_s[0];
    end
  end

  // ********************
  // Register file
  // ********************
  logic [7:0] sreg [NREG];
  logic [7:0] ring_idle;
  logic [7:0] rd_mux;
  wire        idle_hit = tick[TK_TS] && !ring_evt &&
                         ring_idle == RING_IDLE_T - 8'h01;

  for (genvar i = 0; i < NREG; i++) begin : g_reg
    localparam bit RING_SLOT = (i == SL_RING);
    wire hit = req.wr && req.idx == REG_NUM[i];
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        sreg[i] <= REG_RST[i];
      end else if (ce) begin
        if (req.soft_rst && REG_VOL[i]) begin
          sreg[i] <= REG_RST[i]; // [R23]
        end else if (RING_SLOT && ring_evt) begin
          // Saturate so a long ring burst cannot wrap past a match
          if (sreg[i] != 8'hff) sreg[i] <= sreg[i] + 8'h01; // [R3]
        end else if (hit) begin
          sreg[i] <= req.wdata & REG_MASK[i]; // [R24] [R18]
        end else if (RING_SLOT && idle_hit) begin
          sreg[i] <= 8'h00; // [R4]
        end
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    for (int j = 0; j < NREG; j++) begin
      if (req.idx == REG_NUM[j]) rd_mux = sreg[j];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      rd_ack  <= 1'b0;
    end else if (ce) begin
      rd_ack <= req.rd;
      if (req.rd) rd_data <= rd_mux; // [R24]
    end
  end

  // ********************
  // Ring counting and answer
  // ********************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ring_idle <= 8'h00;
      answer_now <= 1'b0;
      auto_answer_indicator <= 1'b0;
    end else if (ce) begin
      if (ring_evt) ring_idle <= 8'h00;
      else if (tick[TK_TS] && ring_idle != RING_IDLE_T) begin
        ring_idle <= ring_idle + 8'h01; // [R4]
      end
      answer_now <= ring_evt && dtr_ok && sreg[SL_ANS] != 8'h00 &&
                    sreg[SL_RING] + 8'h01 == sreg[SL_ANS]; // [R1] [R3]
      auto_answer_indicator <= sreg[SL_ANS] != 8'h00; // [R2]
    end
  end

  // ********************
  // Character handling
  // ********************
  wire esc_on = sreg[SL_ESC] <= ASCII_MAX;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      esc_en <= 1'b0;
      hangup_en <= 1'b0;
      exec_line <= 1'b0;
      esc_hit <= 1'b0;
      bs_hit <= 1'b0;
      eol_char <= 8'h00;
      lf_char <= 8'h00;
      lf_en <= 1'b0;
    end else if (ce) begin
      esc_en <= esc_on; // [R5]
      hangup_en <= esc_on; // [R5]
      esc_hit <= char_valid && esc_on && char_in == sreg[SL_ESC];
      exec_line <= char_valid && char_in == sreg[SL_EOL]; // [R6]
      bs_hit <= char_valid && sreg[SL_BS] < BS_MIN_PRINT &&
                char_in == sreg[SL_BS]; // [R8]
      eol_char <= sreg[SL_EOL]; // [R6]
      lf_char <= sreg[SL_LF]; // [R7]
      lf_en <= verbose_responses; // [R7]
    end
  end

  // ********************
  // Dialing sequencer
  // ********************
  typedef enum logic [2:0] {
    D_IDLE, D_DELAY, D_TONE, D_QUIET, D_PAUSE
  } mccs_dial_t;
  mccs_dial_t d_state;
  logic [7:0] d_cnt;
  logic [7:0] d_lim;

  always_comb begin
    unique case (d_state)
      D_DELAY: d_lim = sreg[SL_DTD];
      D_PAUSE: d_lim = sreg[SL_PAUSE];
      D_IDLE:  d_lim = 8'h00;
      default: d_lim = sreg[SL_CWAIT];
    endcase
  end

  wire d_out = d_cnt >= d_lim;
  wire fast  = result_level == LVL_NODLY_A ||
               result_level == LVL_NODLY_B;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      d_state <= D_IDLE;
      d_cnt <= 8'h00;
      dial_go <= 1'b0;
      dial_fail <= 1'b0;
      quiet_ok <= 1'b0;
      pause_done <= 1'b0;
    end else if (ce) begin
      dial_go <= 1'b0;
      dial_fail <= 1'b0;
      quiet_ok <= 1'b0;
      pause_done <= 1'b0;
      if (d_state == D_IDLE) d_cnt <= 8'h00;
      else if (tick[TK_S] && d_cnt != 8'hff) d_cnt <= d_cnt + 8'h01;
      unique case (d_state)
        D_IDLE: begin
          if (dial_start && wait_tone_mod) d_state <= D_TONE; // [R10]
          else if (dial_start && fast) dial_go <= 1'b1; // [R9]
          else if (dial_start) d_state <= D_DELAY; // [R9]
          else if (quiet_start) d_state <= D_QUIET; // [R11]
          else if (pause_req) d_state <= D_PAUSE; // [R12]
        end
        D_DELAY: if (d_out) begin
          dial_go <= 1'b1; // [R9]
          d_state <= D_IDLE;
        end
        D_TONE: if (pin_s[4] || d_out) begin
          dial_go <= pin_s[4]; // [R10]
          dial_fail <= !pin_s[4];
          d_state <= D_IDLE;
        end
        D_QUIET: if (!pin_s[3] || d_out) begin
          quiet_ok <= !pin_s[3]; // [R11]
          dial_fail <= pin_s[3];
          d_state <= D_IDLE;
        end
        D_PAUSE: if (d_out) begin
          pause_done <= 1'b1; // [R12]
          d_state <= D_IDLE;
        end
      endcase
    end
  end

  // ********************
  // Tone timer
  // ********************
  logic [7:0] t_cnt;
  // Settings under the minimum would break the exchange's digit timing
  wire [7:0] t_lim = sreg[SL_TONE] < TONE_MIN_MS ? TONE_MIN_MS
                                                  : sreg[SL_TONE];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tone_on <= 1'b0;
      t_cnt <= 8'h00;
    end else if (ce) begin
      if (!tone_on) begin
        t_cnt <= 8'h00;
        tone_on <= tone_req;
      end else if (t_cnt >= t_lim) begin
        tone_on <= 1'b0; // [R15]
      end else if (tick[TK_MS]) begin
        t_cnt <= t_cnt + 8'h01;
      end
    end
  end

  // ********************
  // Carrier supervision
  // ********************
  typedef enum logic [1:0] {C_IDLE, C_WAIT, C_ONLINE} mccs_car_t;
  mccs_car_t c_state;
  logic [7:0] w_cnt;
  // Counted in ms so validation is not tick aligned to whole tenths
  logic [15:0] v_cnt;
  wire  [15:0] val_lim  = 16'(sreg[SL_CVAL]) * 16'(DECADE * DECADE);
  wire  [15:0] loss_lim = 16'(sreg[SL_CLOSS]) * 16'(DECADE * DECADE);
  logic [7:0] s_cnt;
  logic       side_pend;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c_state <= C_IDLE;
      w_cnt <= 8'h00;
      v_cnt <= 16'h0000;
      s_cnt <= 8'h00;
      side_pend <= 1'b0;
      carrier_ok <= 1'b0;
      no_carrier <= 1'b0;
      side_go <= 1'b0;
    end else if (ce) begin
      no_carrier <= 1'b0;
      side_go <= 1'b0;
      if (c_state != C_ONLINE || !pin_s[3]) s_cnt <= s_cnt;
      unique case (c_state)
        C_IDLE: begin
          w_cnt <= 8'h00;
          v_cnt <= 16'h0000;
          if (connect_start) c_state <= C_WAIT;
        end
        C_WAIT: begin
          if (tick[TK_S]) w_cnt <= w_cnt + 8'h01;
          if (!pin_s[3]) v_cnt <= 16'h0000;
          else if (tick[TK_MS]) v_cnt <= v_cnt + 16'h0001;
          if (call_end) c_state <= C_IDLE;
          else if (pin_s[3] && v_cnt >= val_lim) begin
            c_state <= C_ONLINE; // [R13]
            carrier_ok <= 1'b1;
            side_pend <= sreg[SL_SIDE] != SIDE_OFF; // [R22]
            s_cnt <= 8'h00;
            v_cnt <= 16'h0000;
          end else if (w_cnt >= sreg[SL_CWAIT]) begin
            no_carrier <= 1'b1; // [R11]
            c_state <= C_IDLE;
          end
        end
        C_ONLINE: begin
          if (pin_s[3]) v_cnt <= 16'h0000;
          else if (tick[TK_MS]) v_cnt <= v_cnt + 16'h0001;
          if (tick[TK_S] && s_cnt != 8'hff) s_cnt <= s_cnt + 8'h01;
          if (side_pend && s_cnt >= sreg[SL_SIDE]) begin
            side_go <= 1'b1; // [R22]
            side_pend <= 1'b0;
          end
          if (call_end || (!pin_s[3] && v_cnt >= loss_lim)) begin
            no_carrier <= !call_end; // [R14]
            carrier_ok <= 1'b0;
            side_pend <= 1'b0;
            c_state <= C_IDLE;
          end
        end
      endcase
    end
  end

  // ********************
  // Terminal-ready and RTS/CTS
  // ********************
  logic [7:0] r_cnt;
  // In ms, so the RTS to CTS delay runs from the RTS edge itself
  logic [11:0] h_cnt;
  wire  [11:0] h_lim = 12'(sreg[SL_RTS]) * 12'(DECADE);
  wire        dtr_tick = (sync_cmd_mode && !online) ? tick[TK_S]
                                                    : tick[TK_HS];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dtr_ok <= 1'b0;
      r_cnt <= 8'h00;
    end else if (ce) begin
      if (pin_s[1] == dtr_ok) r_cnt <= 8'h00;
      else if (r_cnt >= sreg[SL_DTR]) begin
        dtr_ok <= pin_s[1]; // [R20]
        r_cnt <= 8'h00;
      end else if (dtr_tick) r_cnt <= r_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cts <= 1'b0;
      h_cnt <= 12'h000;
    end else if (ce) begin
      if (!pin_s[2]) begin
        cts <= 1'b0; // [R21]
        h_cnt <= 12'h000;
      end else if (h_cnt >= h_lim) cts <= 1'b1; // [R21]
      else if (tick[TK_MS]) h_cnt <= h_cnt + 12'h001;
    end
  end

  // ********************
  // Test limit and decoded settings
  // ********************
  logic [7:0] x_cnt;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      x_cnt <= 8'h00;
      test_stop <= 1'b0;
      bias_step <= 4'h0;
      port_cfg <= '0;
      logon_sel <= 8'h00;
    end else if (ce) begin
      if (!test_active) x_cnt <= 8'h00;
      else if (tick[TK_S] && x_cnt != 8'hff) x_cnt <= x_cnt + 8'h01;
      test_stop <= test_active && tick[TK_S] && sreg[SL_TEST] != 8'h00
                   && x_cnt == sreg[SL_TEST] - 8'h01; // [R17]
      bias_step <= BIAS_MID - (sreg[SL_BIAS] > BIAS_LIM ? BIAS_LIM[3:0]
                               : sreg[SL_BIAS][3:0]); // [R16]
      port_cfg.remote_digital_loopback <= sreg[SL_PORT][PORT_RDL];
      port_cfg.parity <= sreg[SL_PORT][PORT_PAR_HI:PORT_PAR_LO]; // [R18]
      port_cfg.speed <= sreg[SL_PORT][PORT_SPD_HI:PORT_SPD_LO]; // [R19]
      port_cfg.hs <= high_speed_port_setting; // [R19]
      logon_sel <= sreg[SL_LOGON];
    end
  end

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !ce);

  sequence s_dial_fast;
    dial_start && d_state == D_IDLE && !wait_tone_mod && fast;
  endsequence
  sequence s_tone_begin;
    tone_req && !tone_on;
  endsequence

  a_lamp_on: assert property ((sreg[SL_ANS] != 8'h00) |=> // [R2]
    auto_answer_indicator) else $error("indicator not lit");
  a_answer_gate: assert property (answer_now |-> // [R1]
    $past(dtr_ok) && $past(sreg[SL_ANS]) != 8'h00)
    else $error("answer without terminal ready");
  a_ring_step: assert property (ring_evt && !req.soft_rst && // [R3]
    sreg[SL_RING] != 8'hff |=>
    sreg[SL_RING] == $past(sreg[SL_RING]) + 8'h01)
    else $error("ring count did not advance");
  a_ring_clear: assert property (idle_hit && !req.wr && // [R4]
    !req.soft_rst |=> sreg[SL_RING] == 8'h00)
    else $error("ring count not cleared");
  a_escape_off: assert property ((sreg[SL_ESC] > ASCII_MAX) |=> // [R5]
    !esc_en && !hangup_en && !esc_hit)
    else $error("escape still active");
  a_eol_exec: assert property (char_valid && // [R6]
    char_in == sreg[SL_EOL] |=> exec_line)
    else $error("end of line missed");
  a_bs_range: assert property (bs_hit |-> // [R8]
    $past(sreg[SL_BS]) < BS_MIN_PRINT)
    else $error("backspace out of range");
  a_dial_skip: assert property (s_dial_fast |=> dial_go) // [R9]
    else $error("delay not skipped");
  a_tone_hold: assert property (s_tone_begin |=> tone_on [*8]) // [R15]
    else $error("tone too short");
  a_cts_drop: assert property (!pin_s[2] |=> !cts) // [R21]
    else $error("cts without rts");
  a_port_rsvd: assert property (sreg[SL_PORT][7:6] == 2'b00) // [R18]
    else $error("reserved port bits set");
endmodule : mccs_settings

// *** tb/mccs_line_model.sv ***
/*
  Far-side model: terminal handshake lines and the telephone line.
  Assumes the bench calls its tasks from a process clocked on mclk.
*/
`timescale 1ns/100ps
module mccs_line_model (
  input  wire logic mclk,
  output logic      ring_pin,
  output logic      dtr_pin,
  output logic      rts_pin,
  output logic      carrier_pin,
  output logic      dial_tone_pin
);
  // ********************
  // Line levels
  // ********************
  // Terminal ready from power-up, as a real terminal would hold it
  initial begin
    ring_pin      = 1'b0;
    dtr_pin       = 1'b1;
    rts_pin       = 1'b0;
    carrier_pin   = 1'b0;
    dial_tone_pin = 1'b0;
  end

  task automatic ring_once();
    @(posedge mclk);
    ring_pin <= 1'b1;
    repeat (20) @(posedge mclk);
    ring_pin <= 1'b0;
    repeat (20) @(posedge mclk);
  endtask : ring_once

  task automatic set_rts(input logic v);
    @(posedge mclk);
    rts_pin <= v;
  endtask : set_rts

  task automatic set_carrier(input logic v);
    @(posedge mclk);
    carrier_pin <= v;
  endtask : set_carrier
endmodule : mccs_line_model

// *** tb/modem_call_control_settings_tb.sv ***
/*
  Self-checking bench of the settings bank, 1 ms shortened to 10 cycles.
  Assumes the line model drives all asynchronous pins.
*/
`timescale 1ns/100ps
module modem_call_control_settings_tb;
  import mccs_pkg::*;
  localparam int CMS = 10;
  logic       mclk = 0, rst_n = 0, ce = 0, char_valid = 0;
  logic       dial_start = 0, wait_tone_mod = 0, quiet_start = 0;
  logic       pause_req = 0, tone_req = 0, connect_start = 0;
  logic       call_end = 0, test_active = 0, sync_cmd_mode = 0;
  logic       online = 0, verbose_responses = 0;
  logic       high_speed_port_setting = 0;
  logic [2:0] result_level = 0;
  logic [7:0] char_in = 0, rd_data, eol_char, lf_char, logon_sel;
  logic [3:0] bias_step;
  mccs_req_t  req = '0;
  mccs_port_t port_cfg;
  logic rd_ack, auto_answer_indicator, answer_now, esc_en, hangup_en;
  logic exec_line, esc_hit, bs_hit, lf_en, dial_go, dial_fail, quiet_ok;
  logic pause_done, tone_on, carrier_ok, no_carrier, side_go, dtr_ok;
  logic cts, test_stop, ring_pin, dtr_pin, rts_pin, carrier_pin;
  logic dial_tone_pin;
  int   fails = 0, compares = 0, n_ans = 0, n_lost = 0, n_side = 0, n;

  mccs_settings #(.CYC_MS(CMS)) dut (.mclk, .rst_n, .ce, .req, .rd_data,
    .rd_ack, .ring_pin, .dtr_pin, .rts_pin, .carrier_pin, .dial_tone_pin,
    .sync_cmd_mode, .online, .high_speed_port_setting, .verbose_responses,
    .result_level, .char_valid, .char_in, .dial_start, .wait_tone_mod,
    .quiet_start, .pause_req, .tone_req, .connect_start, .call_end,
    .test_active, .auto_answer_indicator, .answer_now, .esc_en, .hangup_en,
    .exec_line, .esc_hit, .bs_hit, .eol_char, .lf_char, .lf_en, .dial_go,
    .dial_fail, .quiet_ok, .pause_done, .tone_on, .carrier_ok, .no_carrier,
    .side_go, .dtr_ok, .cts, .test_stop, .bias_step, .port_cfg, .logon_sel);
  mccs_line_model lm (.mclk, .ring_pin, .dtr_pin, .rts_pin, .carrier_pin,
    .dial_tone_pin);

  // ********************
  // Helpers
  // ********************
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    if (answer_now === 1'b1) n_ans <= n_ans + 1;
    if (no_carrier === 1'b1) n_lost <= n_lost + 1;
    if (side_go === 1'b1) n_side <= n_side + 1;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task automatic bus(input logic w, r, s, input logic [5:0] i,
                     input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: w, rd: r, soft_rst: s, idx: i, wdata: d};
    @(posedge mclk);
    req <= '0;
    #1;
  endtask : bus

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'b1, 1'b0, 1'b0, i, d);
    repeat (2) @(posedge mclk);
    #1;
  endtask : wr

  task automatic rdc(input logic [5:0] i, input logic [7:0] e);
    bus(1'b0, 1'b1, 1'b0, i, 8'h00);
    chk("rd_ack", rd_ack, 1);
    chk("rd_data", rd_data, e);
  endtask : rdc

  task automatic ch(input logic [7:0] c);
    @(posedge mclk);
    char_valid <= 1'b1;
    char_in    <= c;
    @(posedge mclk);
    char_valid <= 1'b0;
    #1;
  endtask : ch

  function automatic logic hit(input int k);
    case (k)
      0:       return cts === 1'b1;
      1:       return carrier_ok === 1'b1;
      2:       return n_lost > 0;
      default: return tone_on !== 1'b1;
    endcase
  endfunction : hit

  // Bounded wait so a stuck output cannot hang the run
  task automatic cnt(input int k);
    n = 0;
    while (!hit(k) && n < 4000) begin
      @(posedge mclk);
      n++;
    end
  endtask : cnt

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    for (int i = 0; i < NREG; i++) rdc(REG_NUM[i], REG_RST[i]);
    rdc(6'h0c, 8'h00);
    chk("port_cfg", port_cfg, 7'h39);
    chk("indicator", auto_answer_indicator, 1);
    chk("bias", bias_step, 4'h0);
    chk("eol", eol_char, 8'h0d);
    chk("lf", lf_char, 8'h0a);
    $display("test reset done");
  endtask : t_reset

  task automatic t_chars();
    ch(8'h0d);
    chk("exec", exec_line, 1);
    ch(8'h08);
    chk("bs", bs_hit, 1);
    ch(8'h2b);
    chk("esc", esc_hit, 1);
    @(posedge mclk) verbose_responses <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("lf_en", lf_en, 1);
    wr(6'h05, 8'h21);
    ch(8'h21);
    chk("bs33", bs_hit, 0);
    wr(6'h05, 8'h20);
    ch(8'h20);
    chk("bs32", bs_hit, 1);
    wr(6'h02, 8'h80);
    chk("esc_en", esc_en, 0);
    chk("hangup", hangup_en, 0);
    ch(8'h80);
    chk("esc_off", esc_hit, 0);
    wr(6'h02, 8'h7f);
    ch(8'h7f);
    chk("esc7f", esc_hit, 1);
    $display("test chars done");
  endtask : t_chars

  task automatic t_ring();
    wr(6'h00, 8'h02);
    lm.ring_once();
    chk("ans1", n_ans, 0);
    lm.ring_once();
    chk("ans2", n_ans, 1);
    rdc(6'h01, 8'h02);
    wr(6'h00, 8'h00);
    chk("ind_off", auto_answer_indicator, 0);
    lm.ring_once();
    chk("ans_off", n_ans, 1);
    wr(6'h03, 8'h2e);
    wr(6'h06, 8'h07);
    bus(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
    rdc(6'h01, 8'h00);
    rdc(6'h03, 8'h0d);
    rdc(6'h06, 8'h07);
    $display("test ring done");
  endtask : t_ring

  task automatic t_timers();
    @(posedge mclk) tone_req <= 1'b1;
    @(posedge mclk) tone_req <= 1'b0;
    #1;
    chk("tone_on", tone_on, 1);
    cnt(3);
    chk("tone_len", n >= 935 && n <= 951, 1);
    lm.set_rts(1'b1);
    cnt(0);
    chk("cts_dly", n >= 88 && n <= 104, 1);
    wr(6'h09, 8'h01);
    wr(6'h0a, 8'h01);
    @(posedge mclk) connect_start <= 1'b1;
    @(posedge mclk) connect_start <= 1'b0;
    lm.set_carrier(1'b1);
    cnt(1);
    chk("valid", n >= 880 && n <= 1020, 1);
    repeat (2) @(posedge mclk);
    chk("side", n_side, 1);
    lm.set_carrier(1'b0);
    cnt(2);
    chk("loss", n >= 880 && n <= 1020, 1);
    repeat (2) @(posedge mclk);
    chk("drop", carrier_ok, 0);
    @(posedge mclk) begin
      result_level <= 3'h2;
      dial_start   <= 1'b1;
    end
    @(posedge mclk) dial_start <= 1'b0;
    #1;
    chk("dial_fast", dial_go, 1);
    wr(6'h08, 8'h00);
    @(posedge mclk) pause_req <= 1'b1;
    @(posedge mclk) pause_req <= 1'b0;
    @(posedge mclk);
    #1;
    chk("pause", pause_done, 1);
    $display("test timers done");
  endtask : t_timers

  task automatic t_rw();
    wr(6'h0d, 8'h00);
    chk("bias0", bias_step, 4'h4);
    wr(6'h0d, 8'h08);
    chk("bias8", bias_step, 4'hc);
    for (int i = 0; i < NREG; i++) begin
      wr(REG_NUM[i], 8'he5);
      rdc(REG_NUM[i], 8'he5 & REG_MASK[i]);
    end
    chk("logon", logon_sel, 8'he5);
    $display("test readwrite done");
  endtask : t_rw

  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    ce    <= 1'b1;
    t_reset();
    repeat (400) @(posedge mclk);
    chk("dtr_early", dtr_ok, 0);
    repeat (200) @(posedge mclk);
    chk("dtr_ok", dtr_ok, 1);
    t_chars();
    t_ring();
    t_timers();
    t_rw();
    tally_and_finish();
  end

  initial begin
    repeat (30000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
endmodule : modem_call_control_settings_tb
